// >>> design/opd_defs.svh
`ifndef OPD_DEFS_SVH
`define OPD_DEFS_SVH
// operand ranges
`define OPD_SADDR_LO    16'hFE20
`define OPD_SADDR_HI    16'hFF1F
`define OPD_SFR_LO      16'hFF00
`define OPD_SFR_HOLE_LO 16'hFFD0
`define OPD_SFR_HOLE_HI 16'hFFDF
`define OPD_CALLF_BASE  16'h0800
`define OPD_CALLT_BASE  16'h0040
`define OPD_HRAM_LO     16'hFB00
`define OPD_HRAM_HI     16'hFEFF
// general register numbers within a bank
`define OPD_R_X 3'h0
`define OPD_R_A 3'h1
`define OPD_R_E 3'h4
`define OPD_R_D 3'h5
`define OPD_R_L 3'h6
`define OPD_R_H 3'h7
// status word bit positions
`define OPD_PSW_IE   7
`define OPD_PSW_Z    6
`define OPD_PSW_RBS1 5
`define OPD_PSW_AC   4
`define OPD_PSW_RBS0 3
`define OPD_PSW_CY   0
`define OPD_PSW_RST  8'h02
// register bus offsets
`define OPD_REG_CTRL 4'h0
`define OPD_REG_STAT 4'h1
`define OPD_REG_PSW  4'h2
`define OPD_REG_GPR  1'h1
`define OPD_CTRL_RST 8'h01
// {bytes, clocks high-speed ram or no access, clocks other area}
`define OPD_T_NONE     {2'h0, 4'h0, 4'h0}
`define OPD_T_R_IMM    {2'h2, 4'h4, 4'h4}
`define OPD_T_A_R      {2'h1, 4'h2, 4'h2}
`define OPD_T_SADDR    {2'h2, 4'h4, 4'h5}
`define OPD_T_SFR      {2'h2, 4'h5, 4'h5}
`define OPD_T_ABS      {2'h3, 4'h8, 4'h9}
`define OPD_T_IND      {2'h1, 4'h4, 4'h5}
`define OPD_T_PSW_A    {2'h2, 4'h5, 4'h5}
`define OPD_T_PSW_IMM  {2'h3, 4'h7, 4'h7}
`define OPD_T_X_SADDR  {2'h2, 4'h4, 4'h6}
`define OPD_T_X_SFR    {2'h2, 4'h6, 4'h6}
`define OPD_T_X_ABS    {2'h3, 4'h8, 4'hA}
`define OPD_T_X_IND    {2'h1, 4'h4, 4'h6}
`define OPD_T_W_RP     {2'h1, 4'h4, 4'h4}
`define OPD_T_W_SADDR  {2'h2, 4'h6, 4'h8}
`define OPD_T_W_SFR    {2'h2, 4'h8, 4'h8}
`define OPD_T_W_ABS    {2'h3, 4'hA, 4'hC}
`endif

// >>> design/opd_pkg.sv
package opd_pkg;
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00, OP_MOV_R_IMM = 5'h01, OP_MOV_A_R   = 5'h02,
    OP_MOV_R_A  = 5'h03, OP_XCH_A_R   = 5'h04, OP_MOV_A_MEM = 5'h05,
    OP_MOV_MEM_A = 5'h06, OP_XCH_A_MEM = 5'h07, OP_MOV_PSW_A = 5'h08,
    OP_MOV_A_PSW = 5'h09, OP_MOV_PSW_IMM = 5'h0A, OP_MOVW_AX_RP = 5'h0B,
    OP_MOVW_RP_AX = 5'h0C, OP_MOVW_MEM_AX = 5'h0D, OP_CALLF = 5'h0E,
    OP_CALLT    = 5'h0F, OP_BR_REL    = 5'h10, OP_SEL_RB    = 5'h11,
    OP_SET1_A   = 5'h12, OP_ADD_A_IMM = 5'h13, OP_CLR1_CY   = 5'h14,
    OP_SET1_CY  = 5'h15, OP_PUSH_PSW  = 5'h16, OP_POP_PSW   = 5'h17
  } opd_op_e;
  typedef enum logic [2:0] {
    FORM_SADDR = 3'h0, FORM_SFR = 3'h1, FORM_ABS = 3'h2,
    FORM_DE = 3'h3, FORM_HL = 3'h4
  } opd_form_e;
  typedef enum logic [2:0] {
    FL_KEEP = 3'h0, FL_CLR = 3'h1, FL_SET = 3'h2, FL_RESULT = 3'h3, FL_RESTORE = 3'h4
  } opd_flag_act_e;
endpackage : opd_pkg

// >>> design/opd_addr_chk.sv
`timescale 1ns/10ps
`include "opd_defs.svh"
module opd_addr_chk (
  // operand
  input  wire opd_pkg::opd_form_e form,
  input  wire logic               wide,
  input  wire logic [15:0]        addr,
  input  wire logic               sfr_wide_ok,
  // verdict
  output logic                    legal
);
  logic in_hole;
  always_comb begin
    in_hole = (addr >= `OPD_SFR_HOLE_LO) && (addr <= `OPD_SFR_HOLE_HI);
    legal   = 1'b1;
    unique case (form)
      opd_pkg::FORM_SADDR: begin
        legal = (addr >= `OPD_SADDR_LO) && (addr <= `OPD_SADDR_HI) && !(wide && addr[0]); // RULE3
      end
      opd_pkg::FORM_SFR: begin
        legal = (addr >= `OPD_SFR_LO) && !in_hole                  // RULE5
                && !(wide && (addr[0] || !sfr_wide_ok));           // RULE4
      end
      opd_pkg::FORM_ABS: begin
        legal = !(wide && addr[0]); // RULE6
      end
      opd_pkg::FORM_DE, opd_pkg::FORM_HL: begin
        legal = !wide;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
endmodule : opd_addr_chk

// >>> design/opd_psw_unit.sv
`timescale 1ns/10ps
`include "opd_defs.svh"
module opd_psw_unit (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // whole-byte writes and bank select
  input  wire logic                  wr_en,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  restore_all,
  input  wire logic                  save_en,
  input  wire logic                  bank_en,
  input  wire logic [1:0]            bank_val,
  // per-flag actions
  input  wire opd_pkg::opd_flag_act_e z_act,
  input  wire opd_pkg::opd_flag_act_e ac_act,
  input  wire opd_pkg::opd_flag_act_e cy_act,
  input  wire logic                  z_res,
  input  wire logic                  ac_res,
  input  wire logic                  cy_res,
  // state
  output logic [7:0]                 psw_q
);
  logic [7:0] psw_d;
  logic [7:0] save_q;
  logic [7:0] save_d;

  function automatic logic flag_next(opd_pkg::opd_flag_act_e act, logic cur, logic res,
                                     logic saved);
    logic v;
    v = cur;
    unique case (act)
      opd_pkg::FL_KEEP:    v = cur;
      opd_pkg::FL_CLR:     v = 1'b0;
      opd_pkg::FL_SET:     v = 1'b1;
      opd_pkg::FL_RESULT:  v = res;
      opd_pkg::FL_RESTORE: v = saved;
      default:             v = cur;
    endcase
    return v;
  endfunction : flag_next

  always_comb begin
    psw_d  = psw_q;
    save_d = save_en ? psw_q : save_q;
    if (restore_all) begin
      psw_d = save_q;
    end else if (wr_en) begin
      psw_d = wr_data; // RULE19
    end else begin
      psw_d[`OPD_PSW_Z]  = flag_next(z_act, psw_q[`OPD_PSW_Z], z_res, save_q[`OPD_PSW_Z]); // RULE15
      psw_d[`OPD_PSW_AC] = flag_next(ac_act, psw_q[`OPD_PSW_AC], ac_res, save_q[`OPD_PSW_AC]);
      psw_d[`OPD_PSW_CY] = flag_next(cy_act, psw_q[`OPD_PSW_CY], cy_res, save_q[`OPD_PSW_CY]);
      if (bank_en) begin
        psw_d[`OPD_PSW_RBS1] = bank_val[1]; // RULE16
        psw_d[`OPD_PSW_RBS0] = bank_val[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      psw_q  <= `OPD_PSW_RST;
      save_q <= `OPD_PSW_RST;
    end else begin
      psw_q  <= psw_d;
      save_q <= save_d;
    end
  end
endmodule : opd_psw_unit

// >>> design/opd_core.sv
// How it works
// RULE1: register numbers 0-7 are X,A,C,B,E,D,L,H
// RULE2: pair numbers 0-3 are AX,BC,DE,HL
// RULE3: short direct FE20-FF1F, 16-bit form even
// RULE4: 16-bit sfr operand: capable register, even
// RULE5: sfr operands never reach FFD0-FFDF
// RULE6: absolute address full range, even if 16-bit
// RULE7: eleven-bit call targets 0800-0FFF only
// RULE8: table call targets even, 0040-007F
// RULE9: bit number is a 3-bit field
// RULE10: branch displacement is signed 8-bit, added
// RULE11: A is the implied 8-bit accumulator
// RULE12: AX pair is the 16-bit accumulator
// RULE13: pair halves separately addressable as bytes
// RULE14: status word holds CY, AC, Z, bank, IE
// RULE15: each flag kept, cleared, set, result, restored
// RULE16: bank operand selects one of four banks
// RULE17: high-speed RAM or no access uses short count
// RULE18: clock counts are CPU clock cycles
// RULE19: fixed transfer timing; status writes update flags
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "opd_defs.svh"
module opd_core (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // decoded instruction
  input  wire logic                instr_valid,
  input  wire opd_pkg::opd_op_e    instr_op,
  input  wire opd_pkg::opd_form_e  instr_form,
  input  wire logic [2:0]          instr_r,
  input  wire logic [1:0]          instr_rp,
  input  wire logic [15:0]         instr_operand,
  input  wire logic [7:0]          instr_imm,
  input  wire logic [7:0]          instr_mdata,
  input  wire logic [15:0]         instr_pc,
  input  wire logic                sfr_wide_ok,
  // result
  output logic                     res_valid_q,
  output logic                     res_fault_q,
  output logic [1:0]               res_bytes_q,
  output logic [3:0]               res_clocks_q,
  output logic [15:0]              res_pc_q,
  // memory write request
  output logic                     mem_we_q,
  output logic                     mem_wide_q,
  output logic [15:0]              mem_addr_q,
  output logic [15:0]              mem_wdata_q,
  // register port
  input  wire logic [3:0]          bus_addr,
  input  wire logic [7:0]          bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic [7:0]               bus_rdata_q
);
  logic [7:0]  gpr_q [0:31];
  logic [7:0]  psw_q;
  logic [7:0]  ctrl_q, ctrl_d, stat_q, stat_d, rdata_d;
  logic        go, wide, legal, is_mem, fault, fast, touch_psw;
  logic [1:0]  bank;
  logic [4:0]  a_idx, r_idx, lo_idx, hi_idx, w0_idx, w1_idx, bw_idx;
  logic        w0_en, w1_en, bw_en;
  logic [7:0]  w0_data, w1_data, a_val, r_val, mem_byte;
  logic [15:0] ax_val, rp_val, eff_addr, tgt_pc, mem_data;
  logic [8:0]  sum;
  logic [9:0]  timing;
  logic        mem_we_d, psw_wr, psw_restore, psw_save, bank_en;
  logic [7:0]  psw_wdata;
  opd_pkg::opd_flag_act_e z_act, ac_act, cy_act;
  logic        z_res, ac_res, cy_res;
  logic        res_valid_d, res_fault_d;

  // register file view, banked by the status word
  always_comb begin
    bank     = {psw_q[`OPD_PSW_RBS1], psw_q[`OPD_PSW_RBS0]}; // RULE14
    a_idx    = {bank, `OPD_R_A};                             // RULE11
    r_idx    = {bank, instr_r};                              // RULE1
    lo_idx   = {bank, instr_rp, 1'b0};                       // RULE2 RULE13
    hi_idx   = {bank, instr_rp, 1'b1};
    a_val    = gpr_q[a_idx];
    r_val    = gpr_q[r_idx];
    ax_val   = {gpr_q[{bank, `OPD_R_A}], gpr_q[{bank, `OPD_R_X}]}; // RULE12
    rp_val   = {gpr_q[hi_idx], gpr_q[lo_idx]};
    unique case (instr_form)
      opd_pkg::FORM_DE: eff_addr = {gpr_q[{bank, `OPD_R_D}], gpr_q[{bank, `OPD_R_E}]};
      opd_pkg::FORM_HL: eff_addr = {gpr_q[{bank, `OPD_R_H}], gpr_q[{bank, `OPD_R_L}]};
      default:          eff_addr = instr_operand;
    endcase
  end

  opd_addr_chk u_addr_chk (
    .form        (instr_form),
    .wide        (wide),
    .addr        (eff_addr),
    .sfr_wide_ok (sfr_wide_ok),
    .legal       (legal)
  );

  opd_psw_unit u_psw (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .wr_en       (psw_wr),
    .wr_data     (psw_wdata),
    .restore_all (psw_restore),
    .save_en     (psw_save),
    .bank_en     (bank_en),
    .bank_val    (instr_imm[1:0]),
    .z_act       (z_act),
    .ac_act      (ac_act),
    .cy_act      (cy_act),
    .z_res       (z_res),
    .ac_res      (ac_res),
    .cy_res      (cy_res),
    .psw_q       (psw_q)
  );

  // instruction execution
  always_comb begin
    go       = instr_valid && ctrl_q[0];
    wide     = (instr_op == opd_pkg::OP_MOVW_MEM_AX);
    is_mem   = (instr_op == opd_pkg::OP_MOV_A_MEM) || (instr_op == opd_pkg::OP_MOV_MEM_A)
               || (instr_op == opd_pkg::OP_XCH_A_MEM) || wide;
    fault    = go && is_mem && !legal;
    // ram behind the short form sits in the fast area; other areas cost a wait except through the sfr form
    fast     = !is_mem || ((eff_addr >= `OPD_HRAM_LO) && (eff_addr <= `OPD_HRAM_HI)); // RULE17
    sum      = {1'b0, a_val} + {1'b0, instr_imm};
    tgt_pc   = instr_pc;
    w0_en    = 1'b0;
    w0_idx   = a_idx;
    w0_data  = a_val;
    w1_en    = 1'b0;
    w1_idx   = r_idx;
    w1_data  = r_val;
    mem_we_d = 1'b0;
    mem_byte = a_val;
    psw_wr   = 1'b0;
    psw_wdata = a_val;
    psw_restore = 1'b0;
    psw_save = 1'b0;
    bank_en  = 1'b0;
    z_act    = opd_pkg::FL_KEEP;
    ac_act   = opd_pkg::FL_KEEP;
    cy_act   = opd_pkg::FL_KEEP;
    z_res    = (sum[7:0] == 8'h00);
    ac_res   = ({1'b0, a_val[3:0]} + {1'b0, instr_imm[3:0]}) > 5'h0F;
    cy_res   = sum[8];
    timing   = `OPD_T_NONE;
    unique case (instr_op)
      opd_pkg::OP_NOP: begin
      end
      opd_pkg::OP_MOV_R_IMM: begin
        {w1_en, w1_data} = {1'b1, instr_imm};
        timing = `OPD_T_R_IMM;
      end
      opd_pkg::OP_MOV_A_R: begin
        {w0_en, w0_data} = {1'b1, r_val};
        timing = `OPD_T_A_R;
      end
      opd_pkg::OP_MOV_R_A: begin
        {w1_en, w1_data} = {1'b1, a_val};
        timing = `OPD_T_A_R;
      end
      opd_pkg::OP_XCH_A_R: begin
        {w0_en, w0_data} = {1'b1, r_val};
        {w1_en, w1_data} = {1'b1, a_val};
        timing = `OPD_T_A_R;
      end
      opd_pkg::OP_MOV_A_MEM, opd_pkg::OP_MOV_MEM_A, opd_pkg::OP_XCH_A_MEM: begin
        w0_en    = (instr_op != opd_pkg::OP_MOV_MEM_A) && legal;
        w0_data  = instr_mdata;
        mem_we_d = (instr_op != opd_pkg::OP_MOV_A_MEM) && legal;
        unique case (instr_form) // RULE19
          opd_pkg::FORM_SADDR: timing = (instr_op == opd_pkg::OP_XCH_A_MEM) ? `OPD_T_X_SADDR
                                                                            : `OPD_T_SADDR;
          opd_pkg::FORM_SFR:   timing = (instr_op == opd_pkg::OP_XCH_A_MEM) ? `OPD_T_X_SFR
                                                                            : `OPD_T_SFR;
          opd_pkg::FORM_ABS:   timing = (instr_op == opd_pkg::OP_XCH_A_MEM) ? `OPD_T_X_ABS
                                                                            : `OPD_T_ABS;
          default:             timing = (instr_op == opd_pkg::OP_XCH_A_MEM) ? `OPD_T_X_IND
                                                                            : `OPD_T_IND;
        endcase
      end
      opd_pkg::OP_MOV_PSW_A, opd_pkg::OP_MOV_PSW_IMM: begin
        psw_wr    = 1'b1; // RULE19
        psw_wdata = (instr_op == opd_pkg::OP_MOV_PSW_A) ? a_val : instr_imm;
        timing    = (instr_op == opd_pkg::OP_MOV_PSW_A) ? `OPD_T_PSW_A : `OPD_T_PSW_IMM;
      end
      opd_pkg::OP_MOV_A_PSW: begin
        {w0_en, w0_data} = {1'b1, psw_q};
        timing = `OPD_T_PSW_A;
      end
      opd_pkg::OP_MOVW_AX_RP, opd_pkg::OP_MOVW_RP_AX: begin
        w0_en   = 1'b1;
        w1_en   = 1'b1;
        // X and A are the low and high halves of the wide accumulator
        w0_idx  = (instr_op == opd_pkg::OP_MOVW_AX_RP) ? a_idx : hi_idx; // RULE12 RULE13
        w0_data = (instr_op == opd_pkg::OP_MOVW_AX_RP) ? rp_val[15:8] : ax_val[15:8];
        w1_idx  = (instr_op == opd_pkg::OP_MOVW_AX_RP) ? {bank, `OPD_R_X} : lo_idx;
        w1_data = (instr_op == opd_pkg::OP_MOVW_AX_RP) ? rp_val[7:0] : ax_val[7:0];
        timing  = `OPD_T_W_RP;
      end
      opd_pkg::OP_MOVW_MEM_AX: begin
        mem_we_d = legal;
        timing = (instr_form == opd_pkg::FORM_SADDR) ? `OPD_T_W_SADDR
               : (instr_form == opd_pkg::FORM_SFR) ? `OPD_T_W_SFR : `OPD_T_W_ABS;
      end
      opd_pkg::OP_CALLF: begin
        tgt_pc = `OPD_CALLF_BASE | {5'h00, instr_operand[10:0]}; // RULE7
      end
      opd_pkg::OP_CALLT: begin
        tgt_pc = `OPD_CALLT_BASE | {10'h000, instr_operand[4:0], 1'b0}; // RULE8
      end
      opd_pkg::OP_BR_REL: begin
        tgt_pc = instr_pc + {{8{instr_imm[7]}}, instr_imm}; // RULE10
      end
      opd_pkg::OP_SEL_RB: begin
        bank_en = 1'b1; // RULE16
      end
      opd_pkg::OP_SET1_A: begin
        {w0_en, w0_data} = {1'b1, a_val | (8'h01 << instr_imm[2:0])}; // RULE9
      end
      opd_pkg::OP_ADD_A_IMM: begin
        {w0_en, w0_data} = {1'b1, sum[7:0]};
        z_act  = opd_pkg::FL_RESULT; // RULE15
        ac_act = opd_pkg::FL_RESULT;
        cy_act = opd_pkg::FL_RESULT;
      end
      opd_pkg::OP_CLR1_CY: cy_act = opd_pkg::FL_CLR;
      opd_pkg::OP_SET1_CY: cy_act = opd_pkg::FL_SET;
      opd_pkg::OP_PUSH_PSW: psw_save = 1'b1;
      opd_pkg::OP_POP_PSW: psw_restore = 1'b1;
      default: begin
      end
    endcase
    mem_data = wide ? ax_val : {8'h00, mem_byte};
    touch_psw = go && (psw_wr || psw_restore || bank_en || (z_act != opd_pkg::FL_KEEP)
                || (cy_act != opd_pkg::FL_KEEP));
    // a disabled core or an illegal operand writes no register, memory or status word
    if (!go || fault) begin
      {w0_en, w1_en, mem_we_d, psw_wr, psw_restore, psw_save, bank_en} = 7'h00;
      z_act  = opd_pkg::FL_KEEP;
      ac_act = opd_pkg::FL_KEEP;
      cy_act = opd_pkg::FL_KEEP;
    end
    // software status writes lose to an instruction touching the status word
    if (bus_wr && (bus_addr == `OPD_REG_PSW) && !touch_psw) begin
      psw_wr    = 1'b1;
      psw_wdata = bus_wdata;
    end
    res_valid_d = go;
    res_fault_d = fault;
  end

  // register port
  always_comb begin
    bw_en  = bus_wr && (bus_addr[3] == `OPD_REG_GPR);
    bw_idx = {bank, bus_addr[2:0]};
    ctrl_d = (bus_wr && bus_addr == `OPD_REG_CTRL) ? bus_wdata : ctrl_q;
    stat_d = stat_q;
    if (bus_wr && bus_addr == `OPD_REG_STAT) begin
      stat_d = stat_q & ~bus_wdata;
    end
    if (fault) begin
      stat_d[0] = 1'b1; // a new fault wins over a clear in the same cycle
    end
    rdata_d = 8'h00;
    if (bus_rd) begin
      if (bus_addr[3] == `OPD_REG_GPR) begin
        rdata_d = gpr_q[bw_idx];
      end else if (bus_addr == `OPD_REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (bus_addr == `OPD_REG_STAT) begin
        rdata_d = stat_q;
      end else if (bus_addr == `OPD_REG_PSW) begin
        rdata_d = psw_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= 8'h00;
      end
      ctrl_q       <= `OPD_CTRL_RST;
      stat_q       <= 8'h00;
      bus_rdata_q  <= 8'h00;
      res_valid_q  <= 1'b0;
      res_fault_q  <= 1'b0;
      res_bytes_q  <= 2'h0;
      res_clocks_q <= 4'h0;
      res_pc_q     <= 16'h0000;
      mem_we_q     <= 1'b0;
      mem_wide_q   <= 1'b0;
      mem_addr_q   <= 16'h0000;
      mem_wdata_q  <= 16'h0000;
    end else begin
      if (bw_en) begin
        gpr_q[bw_idx] <= bus_wdata;
      end
      if (w1_en) begin
        gpr_q[w1_idx] <= w1_data;
      end
      if (w0_en) begin
        gpr_q[w0_idx] <= w0_data;
      end
      ctrl_q       <= ctrl_d;
      stat_q       <= stat_d;
      bus_rdata_q  <= rdata_d;
      res_valid_q  <= res_valid_d;
      res_fault_q  <= res_fault_d;
      res_bytes_q  <= timing[9:8];
      res_clocks_q <= fast ? timing[7:4] : timing[3:0]; // RULE17 RULE18
      res_pc_q     <= tgt_pc;
      mem_we_q     <= mem_we_d;
      mem_wide_q   <= wide;
      mem_addr_q   <= eff_addr;
      mem_wdata_q  <= mem_data;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_saddr_low: assert property (go && is_mem && instr_form == opd_pkg::FORM_SADDR // RULE3
      && eff_addr < `OPD_SADDR_LO |=> res_fault_q && !mem_we_q)
    else $error("short direct below range not refused");
  chk_sfr_hole: assert property (go && is_mem && instr_form == opd_pkg::FORM_SFR // RULE5
      && eff_addr >= `OPD_SFR_HOLE_LO && eff_addr <= `OPD_SFR_HOLE_HI |=> res_fault_q)
    else $error("sfr hole reached");
  chk_wide_even: assert property (mem_we_q && mem_wide_q |-> !mem_addr_q[0]) // RULE6
    else $error("odd 16-bit write issued");
  chk_callf_rng: assert property (go && instr_op == opd_pkg::OP_CALLF // RULE7
      |=> res_pc_q >= `OPD_CALLF_BASE && res_pc_q <= 16'h0FFF)
    else $error("eleven-bit call out of range");
  chk_callt_rng: assert property (go && instr_op == opd_pkg::OP_CALLT // RULE8
      |=> !res_pc_q[0] && res_pc_q >= `OPD_CALLT_BASE && res_pc_q <= 16'h007F)
    else $error("table call target bad");
  chk_branch_back: assert property (go && instr_op == opd_pkg::OP_BR_REL && instr_imm[7] // RULE10
      && instr_pc >= 16'h0080 |=> res_pc_q < $past(instr_pc))
    else $error("negative displacement did not go back");
  chk_psw_load: assert property (go && instr_op == opd_pkg::OP_MOV_PSW_A // RULE19
      |=> psw_q == $past(a_val))
    else $error("status word not loaded from A");
  chk_xch_swap: assert property (go && instr_op == opd_pkg::OP_XCH_A_R && instr_r != `OPD_R_A // RULE1
      |=> gpr_q[a_idx] == $past(r_val))
    else $error("exchange did not reach A");
  chk_slow_abs: assert property (go && instr_op == opd_pkg::OP_MOV_A_MEM // RULE17
      && instr_form == opd_pkg::FORM_ABS && !fast |=> res_clocks_q == 4'h9)
    else $error("slow absolute load count wrong");
  chk_rdata_psw: assert property (bus_rd && bus_addr == `OPD_REG_PSW |=> bus_rdata_q == $past(psw_q))
    else $error("status word read wrong");

  cov_xch_mem: cover property (go && instr_op == opd_pkg::OP_XCH_A_MEM && legal);
  cov_fault: cover property (res_fault_q);
  cov_restore: cover property (go && instr_op == opd_pkg::OP_POP_PSW);
  cov_bank3: cover property (bank == 2'h3 ##1 go);
endmodule : opd_core

// >>> tb/opd_mem_model.sv
`timescale 1ns/10ps
module opd_mem_model (
  // clock
  input  wire logic        clk_sys,
  // write request
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  // read port
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data
);
  // low address byte only: short tests never collide
  logic [7:0] mem_q [256];
  initial for (int i = 0; i < 256; i++) mem_q[i] = 8'h00;
  assign rd_data = mem_q[rd_addr[7:0]];
  always @(posedge clk_sys) begin
    if (mem_we) mem_q[mem_addr[7:0]] <= mem_wdata;
  end
endmodule : opd_mem_model

// >>> tb/tb_opd_core.sv
`timescale 1ns/10ps
`include "opd_defs.svh"
module tb_opd_core;
  logic                 clk_sys, reset_n, instr_valid, bus_wr, bus_rd;
  logic                 sfr_wide_ok, res_valid_q, res_fault_q, mem_we_q, mem_wide_q;
  opd_pkg::opd_op_e     instr_op;
  opd_pkg::opd_form_e   instr_form;
  logic [2:0]           instr_r;
  logic [1:0]           instr_rp, res_bytes_q;
  logic [3:0]           bus_addr, res_clocks_q;
  logic [7:0]           instr_imm, instr_mdata, bus_wdata, bus_rdata_q;
  logic [15:0]          instr_operand, instr_pc, res_pc_q, mem_addr_q, mem_wdata_q;
  int                   failures, tests_run;
  opd_core opd_core_inst (.*);
  opd_mem_model opd_mem_model_inst (.clk_sys(clk_sys), .mem_we(mem_we_q),
    .mem_addr(mem_addr_q), .mem_wdata(mem_wdata_q[7:0]), .rd_addr(instr_operand),
    .rd_data(instr_mdata));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 chk("rdata", {8'h00, bus_rdata_q}, {8'h00, exp});
  endtask : rd
  // k: 0 executes, 1 faults, 2 refused
  task automatic exec(input opd_pkg::opd_op_e op, input opd_pkg::opd_form_e fm,
                      input logic [15:0] opnd, input logic [2:0] r, input logic [7:0] imm,
                      input int k);
    @(posedge clk_sys);
    instr_valid   <= 1'b1;
    instr_op      <= op;
    instr_form    <= fm;
    instr_r       <= r;
    instr_rp      <= r[1:0];
    instr_operand <= opnd;
    instr_imm     <= imm;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1 chk("run", {15'h0, res_valid_q | res_fault_q}, {15'h0, k != 2});
    chk("fault", {15'h0, res_fault_q}, {15'h0, k == 1});
  endtask : exec
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    {reset_n, instr_valid, bus_wr, bus_rd, instr_r, instr_rp, instr_imm} = '0;
    {bus_addr, bus_wdata, instr_operand} = '0;
    instr_op    = opd_pkg::OP_NOP;
    instr_form  = opd_pkg::FORM_SADDR;
    instr_pc    = 16'h1000;
    sfr_wide_ok = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`OPD_REG_CTRL, 8'h01);
    rd(`OPD_REG_STAT, 8'h00);
    rd(`OPD_REG_PSW, 8'h02);
    rd(4'h3, 8'h00);
    $display("done reset");
    for (int r = 0; r < 8; r++) begin
      exec(opd_pkg::OP_MOV_R_IMM, opd_pkg::FORM_SADDR, 16'h0, 3'(r), 8'hA0 + 8'(r), 0);
      chk("len", {res_bytes_q, res_clocks_q}, 6'h24);
      rd(4'h8 + 4'(r), 8'hA0 + 8'(r));
    end
    exec(opd_pkg::OP_MOV_A_R, opd_pkg::FORM_SADDR, 16'h0, 3'h2, 8'h0, 0);
    rd(4'h9, 8'hA2);
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SADDR, 16'hFE20, 3'h0, 8'h0, 0);
    chk("mem", {mem_we_q, mem_wdata_q[14:0]}, 16'h80A2);
    chk("addr", mem_addr_q, 16'hFE20);
    chk("clk", res_clocks_q, 4'h4);
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SADDR, 16'hFF1F, 3'h0, 8'h0, 0);
    chk("clk", res_clocks_q, 4'h5);
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SADDR, 16'hFE1F, 3'h0, 8'h0, 1);
    rd(`OPD_REG_STAT, 8'h01);
    wr(`OPD_REG_STAT, 8'h01);
    rd(`OPD_REG_STAT, 8'h00);
    exec(opd_pkg::OP_MOV_A_R, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h0, 0);
    exec(opd_pkg::OP_MOV_A_MEM, opd_pkg::FORM_SADDR, 16'hFE20, 3'h0, 8'h0, 0);
    rd(4'h9, 8'hA2);
    $display("done byte ops");
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SFR, 16'hFFD0, 3'h0, 8'h0, 1);
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SFR, 16'hFFDF, 3'h0, 8'h0, 1);
    exec(opd_pkg::OP_MOV_MEM_A, opd_pkg::FORM_SFR, 16'hFFE0, 3'h0, 8'h0, 0);
    exec(opd_pkg::OP_MOVW_MEM_AX, opd_pkg::FORM_ABS, 16'h0101, 3'h0, 8'h0, 1);
    exec(opd_pkg::OP_MOVW_MEM_AX, opd_pkg::FORM_SADDR, 16'hFE21, 3'h0, 8'h0, 1);
    sfr_wide_ok <= 1'b0;
    exec(opd_pkg::OP_MOVW_MEM_AX, opd_pkg::FORM_SFR, 16'hFF10, 3'h0, 8'h0, 1);
    sfr_wide_ok <= 1'b1;
    exec(opd_pkg::OP_MOVW_MEM_AX, opd_pkg::FORM_ABS, 16'h0100, 3'h0, 8'h0, 0);
    chk("wide", {14'h0, mem_wide_q, mem_we_q}, 16'h0003);
    chk("wdata", mem_wdata_q, 16'hA2A0);
    exec(opd_pkg::OP_MOVW_RP_AX, opd_pkg::FORM_SADDR, 16'h0, 3'h3, 8'h0, 0);
    rd(4'hF, 8'hA2);
    rd(4'hE, 8'hA0);
    exec(opd_pkg::OP_XCH_A_R, opd_pkg::FORM_SADDR, 16'h0, 3'h3, 8'h0, 0);
    rd(4'hB, 8'hA2);
    exec(opd_pkg::OP_SET1_A, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'hFC, 0);
    rd(4'h9, 8'hB3);
    exec(opd_pkg::OP_MOVW_AX_RP, opd_pkg::FORM_SADDR, 16'h0, 3'h2, 8'h0, 0);
    rd(4'h9, 8'hA5);
    exec(opd_pkg::OP_ADD_A_IMM, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h5B, 0);
    rd(`OPD_REG_PSW, 8'h53);
    exec(opd_pkg::OP_MOV_PSW_A, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h0, 0);
    rd(`OPD_REG_PSW, 8'h00);
    exec(opd_pkg::OP_MOV_A_MEM, opd_pkg::FORM_ABS, 16'h0100, 3'h0, 8'h0, 0);
    chk("clk", res_clocks_q, 16'h0009);
    rd(4'h9, 8'hA0);
    $display("done wide ops");
    exec(opd_pkg::OP_CALLF, opd_pkg::FORM_SADDR, 16'hF923, 3'h0, 8'h0, 0);
    chk("pc", res_pc_q, 16'h0923);
    exec(opd_pkg::OP_CALLT, opd_pkg::FORM_SADDR, 16'hFFFF, 3'h0, 8'h0, 0);
    chk("pc", res_pc_q, 16'h007E);
    exec(opd_pkg::OP_BR_REL, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'hFE, 0);
    chk("pc", res_pc_q, 16'h0FFE);
    exec(opd_pkg::OP_BR_REL, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h7F, 0);
    chk("pc", res_pc_q, 16'h107F);
    $display("done targets");
    exec(opd_pkg::OP_MOV_PSW_IMM, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'hD3, 0);
    rd(`OPD_REG_PSW, 8'hD3);
    exec(opd_pkg::OP_SEL_RB, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h02, 0);
    rd(`OPD_REG_PSW, 8'hF3);
    rd(4'h8, 8'h00);
    exec(opd_pkg::OP_CLR1_CY, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h0, 0);
    rd(`OPD_REG_PSW, 8'hF2);
    exec(opd_pkg::OP_PUSH_PSW, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h0, 0);
    exec(opd_pkg::OP_MOV_PSW_IMM, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h02, 0);
    exec(opd_pkg::OP_POP_PSW, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h0, 0);
    rd(`OPD_REG_PSW, 8'hF2);
    $display("done status word");
    wr(`OPD_REG_CTRL, 8'h00);
    exec(opd_pkg::OP_MOV_R_IMM, opd_pkg::FORM_SADDR, 16'h0, 3'h0, 8'h55, 2);
    rd(4'h8, 8'h00);
    $display("done refusal");
    test_done();
  end
endmodule : tb_opd_core
